// *** design/mmfl_pkg.sv ***
package mmfl_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0] MMFL_TEMP_FLAG_OFS  = 8'h06;
    localparam logic [7:0] MMFL_SUPPLY_FLAG_OFS = 8'h07;
    localparam logic [7:0] MMFL_IRQ_STATUS_OFS = 8'h08;
    localparam logic [7:0] MMFL_IRQ_MASK_OFS   = 8'h09;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int MMFL_HI_ALARM_POS = 7;
    localparam int MMFL_LO_ALARM_POS = 6;
    localparam int MMFL_HI_WARN_POS  = 5;
    localparam int MMFL_LO_WARN_POS  = 4;
    localparam int MMFL_INIT_POS     = 0;

    // interrupt status/mask layout: bit 0 temp event, bit 1 supply event, bit 2 init done
    localparam int MMFL_IRQ_TEMP_POS   = 0;
    localparam int MMFL_IRQ_SUPPLY_POS = 1;
    localparam int MMFL_IRQ_INIT_POS   = 2;
    localparam int MMFL_IRQ_BITS       = 3;

    // ****************************************************************
    // reset values and timing
    // ****************************************************************
    localparam logic [7:0] MMFL_FLAG_RST   = 8'h00;
    localparam logic [2:0] MMFL_IRQ_RST    = 3'h0;
    localparam int         MMFL_INIT_NS    = 1000;
    localparam int         MMFL_CLK_NS     = 8;
    localparam int         MMFL_INIT_CYC   = (MMFL_INIT_NS + MMFL_CLK_NS - 1) / MMFL_CLK_NS;

endpackage

// *** design/mmfl_latch4.sv ***
`timescale 1ns/100ps
module mmfl_latch4
    import mmfl_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic [3:0] cond_i,
    input  wire logic       rd_clr_i,
    output logic      [3:0] flags_o,
    output logic            rise_o
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [3:0] flags;
        logic [3:0] cond_d;
    } mmfl_l4_state_t;

    mmfl_l4_state_t st_ff;
    mmfl_l4_state_t nxt_st;
    logic [3:0]     set_v;

    always_comb begin
        nxt_st = st_ff;
        set_v  = cond_i & ~st_ff.cond_d;
        // a live condition re-sets on the read cycle so it is never lost
        if (rd_clr_i) begin
            nxt_st.flags = cond_i | set_v;
        end else begin
            nxt_st.flags = st_ff.flags | set_v | cond_i;
        end
        nxt_st.cond_d = cond_i;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign flags_o = st_ff.flags;
    assign rise_o  = |(st_ff.cond_d & ~st_ff.flags) | 1'b0;
endmodule

// *** design/mmfl_init_timer.sv ***
`timescale 1ns/100ps
module mmfl_init_timer
    import mmfl_pkg::*;
#(
    parameter int INIT_CYC = MMFL_INIT_CYC
) (
    input  wire logic clk_i,
    input  wire logic resetn_i,
    output logic      done_o
);
    // the counter is 16 bits wide, so longer init times cannot be served
    if (INIT_CYC < 1 || INIT_CYC > 65535) begin : g_bad_init_cyc
        $error("INIT_CYC out of range");
    end

    typedef struct packed {
        logic [15:0] cnt;
        logic        done;
    } mmfl_it_state_t;

    mmfl_it_state_t st_ff;
    mmfl_it_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (!st_ff.done) begin
            if (st_ff.cnt == 16'(INIT_CYC - 1)) begin
                nxt_st.done = 1'b1;
            end else begin
                nxt_st.cnt = 16'(st_ff.cnt + 16'h0001);
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign done_o = st_ff.done;
endmodule

// *** design/mmfl_top.sv ***
// Functional notes
// - temp byte: bit 7 latched high alarm, bit 6 latched low alarm
// - temp byte: bit 5 latched high temperature warning
// - temp byte: bit 4 latched low temperature warning
// - temp bit 0 sets when init finishes, clears when byte is read
// - supply byte: bit 7 latched high voltage alarm
// - supply byte: bit 6 latched low voltage alarm
// - supply byte: bit 5 latched high voltage warning
// - supply byte: bit 4 latched low voltage warning
//
// Local design decision: strobed register access.
`timescale 1ns/100ps
module mmfl_top
    import mmfl_pkg::*;
#(
    parameter int INIT_CYC = MMFL_INIT_CYC
) (
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       temp_hi_alarm_i,
    input  wire logic       temp_lo_alarm_i,
    input  wire logic       temp_hi_warn_i,
    input  wire logic       temp_lo_warn_i,
    input  wire logic       vcc_hi_alarm_i,
    input  wire logic       vcc_lo_alarm_i,
    input  wire logic       vcc_hi_warn_i,
    input  wire logic       vcc_lo_warn_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    output logic            irq_o
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [7:0]               rdata;
        logic                     irq;
        logic                     init_flag;
        logic                     init_seen;
        logic [MMFL_IRQ_BITS-1:0] irq_status;
        logic [MMFL_IRQ_BITS-1:0] irq_mask;
    } mmfl_state_t;

    mmfl_state_t st_ff;
    mmfl_state_t nxt_st;

    logic [3:0] temp_flags;
    logic [3:0] vcc_flags;
    logic       init_done;
    logic       rd_temp;
    logic       rd_vcc;
    logic [3:0] temp_prev_ff;
    logic [3:0] vcc_prev_ff;

    function automatic logic [7:0] flag_byte(input logic [3:0] f, input logic low);
        // upper nibble holds the four latches; low bits reserved except bit 0
        flag_byte = {f, 3'h0, low};
    endfunction

    assign rd_temp = rd_i && (addr_i == MMFL_TEMP_FLAG_OFS);
    assign rd_vcc  = rd_i && (addr_i == MMFL_SUPPLY_FLAG_OFS);

    // ****************************************************************
    // latches
    // ****************************************************************
    mmfl_latch4 u_temp (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .cond_i   ({temp_hi_alarm_i, temp_lo_alarm_i, temp_hi_warn_i, temp_lo_warn_i}),
        .rd_clr_i (rd_temp),
        .flags_o  (temp_flags),
        .rise_o   ()
    );

    mmfl_latch4 u_vcc (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .cond_i   ({vcc_hi_alarm_i, vcc_lo_alarm_i, vcc_hi_warn_i, vcc_lo_warn_i}),
        .rd_clr_i (rd_vcc),
        .flags_o  (vcc_flags),
        .rise_o   ()
    );

    mmfl_init_timer #(
        .INIT_CYC (INIT_CYC)
    ) u_init (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .done_o   (init_done)
    );

    // previous flag values for interrupt event detection
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            temp_prev_ff <= 4'h0;
            vcc_prev_ff  <= 4'h0;
        end else begin
            temp_prev_ff <= temp_flags;
            vcc_prev_ff  <= vcc_flags;
        end
    end

    // ****************************************************************
    // register file
    // ****************************************************************
    always_comb begin
        logic [MMFL_IRQ_BITS-1:0] ev;
        logic [MMFL_IRQ_BITS-1:0] clr;
        ev  = '0;
        clr = '0;
        nxt_st = st_ff;

        // init flag: one-shot set when the init timer first completes
        if (init_done && !st_ff.init_seen) begin
            nxt_st.init_flag = 1'b1;
            nxt_st.init_seen = 1'b1;
            ev[MMFL_IRQ_INIT_POS] = 1'b1;
        end else if (rd_temp) begin
            nxt_st.init_flag = 1'b0;
        end

        ev[MMFL_IRQ_TEMP_POS]   = |(temp_flags & ~temp_prev_ff);
        ev[MMFL_IRQ_SUPPLY_POS] = |(vcc_flags & ~vcc_prev_ff);

        if (wr_i && addr_i == MMFL_IRQ_STATUS_OFS) begin
            clr = wdata_i[MMFL_IRQ_BITS-1:0];
        end
        if (wr_i && addr_i == MMFL_IRQ_MASK_OFS) begin
            nxt_st.irq_mask = wdata_i[MMFL_IRQ_BITS-1:0];
        end
        // set wins over a simultaneous write-one clear
        nxt_st.irq_status = (st_ff.irq_status & ~clr) | ev;
        nxt_st.irq        = |(nxt_st.irq_status & nxt_st.irq_mask);

        nxt_st.rdata = 8'h00;
        if (rd_i) begin
            case (addr_i)
                MMFL_TEMP_FLAG_OFS:   nxt_st.rdata = flag_byte(temp_flags, st_ff.init_flag);
                MMFL_SUPPLY_FLAG_OFS: nxt_st.rdata = flag_byte(vcc_flags, 1'b0);
                MMFL_IRQ_STATUS_OFS:  nxt_st.rdata = {5'h00, st_ff.irq_status};
                MMFL_IRQ_MASK_OFS:    nxt_st.rdata = {5'h00, st_ff.irq_mask};
                default:              nxt_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_ff.rdata      <= MMFL_FLAG_RST;
            st_ff.irq        <= 1'b0;
            st_ff.init_flag  <= 1'b0;
            st_ff.init_seen  <= 1'b0;
            st_ff.irq_status <= MMFL_IRQ_RST;
            st_ff.irq_mask   <= MMFL_IRQ_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rdata_o = st_ff.rdata;
    assign irq_o   = st_ff.irq;
endmodule

// *** bench/mmfl_asserts.sv ***
`timescale 1ns/100ps
module mmfl_asserts
    import mmfl_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       temp_hi_alarm_i,
    input  wire logic       vcc_hi_alarm_i,
    input  wire logic       vcc_lo_warn_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic [7:0] rdata_o,
    input  wire logic       irq_o
);
    // ****************************************************************
    // read port, flag and interrupt mask checks
    // ****************************************************************
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data not idle");
    a_temp_rsvd: assert property (rd_i && addr_i == 8'h06 |=> rdata_o[3:1] == 3'h0)
        else $error("temp reserved bits set");
    a_vcc_rsvd: assert property (rd_i && addr_i == 8'h07 |=> rdata_o[3:0] == 4'h0)
        else $error("supply reserved bits set");
    a_temp_hi: assert property (temp_hi_alarm_i ##1 (rd_i && addr_i == 8'h06) |=> rdata_o[7])
        else $error("temp high alarm lost");
    a_vcc_hi: assert property (vcc_hi_alarm_i ##1 (rd_i && addr_i == 8'h07) |=> rdata_o[7])
        else $error("supply high alarm lost");
    a_vcc_lo_warn: assert property (vcc_lo_warn_i ##1 (rd_i && addr_i == 8'h07) |=> rdata_o[4])
        else $error("supply low warning lost");
    a_init_clear: assert property ((rd_i && addr_i == 8'h06) ##2 (rd_i && addr_i == 8'h06)
        |=> !rdata_o[0]) else $error("init flag not cleared");
    a_unmapped_zero: assert property (rd_i && addr_i > 8'h09 |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_irq_masked: assert property (wr_i && addr_i == 8'h09 && wdata_i == 8'h00 |=> ##1 !irq_o)
        else $error("irq high with mask clear");
endmodule
bind mmfl_top mmfl_asserts u_chk (.clk_i(clk_i), .resetn_i(resetn_i),
    .temp_hi_alarm_i(temp_hi_alarm_i), .vcc_hi_alarm_i(vcc_hi_alarm_i),
    .vcc_lo_warn_i(vcc_lo_warn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));

// *** bench/mmfl_cond_src.sv ***
`timescale 1ns/100ps
module mmfl_cond_src (
    input  wire logic [7:0] cond_i,
    output logic      [3:0] temp_o,
    output logic      [3:0] vcc_o
);
    // live monitor levels, msb of each nibble is the high alarm
    assign temp_o = cond_i[7:4];
    assign vcc_o  = cond_i[3:0];
endmodule

// *** bench/mmfl_top_bench.sv ***
`timescale 1ns/100ps
module mmfl_top_bench;
    logic       clk_i = 1'b0;
    logic       resetn_i = 1'b0;
    logic [7:0] cond = 8'h00;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [7:0] rdata;
    logic       irq;
    logic [3:0] temp;
    logic [3:0] vcc;
    logic [7:0] d;
    int         n_errors = 0;
    int         tests_run = 0;
    int         cyc = 0;
    mmfl_cond_src u_src (.cond_i(cond), .temp_o(temp), .vcc_o(vcc));
    // short init count keeps the run brief
    mmfl_top #(.INIT_CYC(4)) u_dut (.clk_i(clk_i), .resetn_i(resetn_i),
        .temp_hi_alarm_i(temp[3]), .temp_lo_alarm_i(temp[2]), .temp_hi_warn_i(temp[1]),
        .temp_lo_warn_i(temp[0]), .vcc_hi_alarm_i(vcc[3]), .vcc_lo_alarm_i(vcc[2]),
        .vcc_hi_warn_i(vcc[1]), .vcc_lo_warn_i(vcc[0]), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq));
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_i);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask
    task automatic pulse(input logic [7:0] c);
        @(posedge clk_i);
        cond <= c;
        @(posedge clk_i);
        cond <= 8'h00;
    endtask
    task automatic irq_is(input logic exp);
        repeat (2) @(posedge clk_i);
        #1 chk("irq", {7'h00, exp}, {7'h00, irq});
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            end_sim();
        end
    end
    initial begin
        repeat (4) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        rd_reg(8'h06); chk("temp init", 8'h01, d);
        rd_reg(8'h06); chk("temp reread", 8'h00, d);
        rd_reg(8'h07); chk("supply idle", 8'h00, d);
        $display("test init done");
        for (int i = 0; i < 8; i++) begin
            pulse(8'h01 << i);
            rd_reg(i < 4 ? 8'h07 : 8'h06);
            chk("flag set", 8'h10 << (i % 4), d);
            rd_reg(i < 4 ? 8'h07 : 8'h06);
            chk("flag cleared", 8'h00, d);
        end
        $display("test flag bits done");
        @(posedge clk_i);
        cond <= 8'h80;
        rd_reg(8'h06); chk("held 1", 8'h80, d);
        rd_reg(8'h06); chk("held 2", 8'h80, d);
        @(posedge clk_i);
        cond <= 8'h00;
        rd_reg(8'h06); chk("held 3", 8'h80, d);
        rd_reg(8'h06); chk("held 4", 8'h00, d);
        @(posedge clk_i);
        cond <= 8'h09;
        rd_reg(8'h07); chk("vcc held 1", 8'h90, d);
        @(posedge clk_i);
        cond <= 8'h00;
        rd_reg(8'h07); chk("vcc held 2", 8'h90, d);
        rd_reg(8'h07); chk("vcc held 3", 8'h00, d);
        wr_reg(8'h06, 8'hFF);
        rd_reg(8'h06); chk("ro write", 8'h00, d);
        rd_reg(8'h20); chk("unmapped", 8'h00, d);
        $display("test hold and refuse done");
        rd_reg(8'h08); chk("irq status", 8'h07, d);
        irq_is(1'b0);
        wr_reg(8'h09, 8'h01);
        irq_is(1'b1);
        wr_reg(8'h08, 8'h07);
        irq_is(1'b0);
        rd_reg(8'h08); chk("status clr", 8'h00, d);
        pulse(8'h08);
        irq_is(1'b0);
        wr_reg(8'h09, 8'h02);
        irq_is(1'b1);
        wr_reg(8'h09, 8'h00);
        irq_is(1'b0);
        $display("test irq done");
        end_sim();
    end
endmodule
